/* File: rtl/cst_skip_core.sv */
/*
  Skip-test and detector-enable slice of the 4-bit core decoder.
  Assumes one instruction word is offered per valid cycle, the memory
  nibble at the data pointer, carry and port pins are current in that cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cst_skip_core
  import cst_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic instr_valid_in,
  input wire logic [9:0] instr_in,
  input wire logic [3:0] mem_nibble_in,
  input wire logic carry_flag_in,
  input wire logic [CST_PORT_W-1:0] port_pins_in,
  input wire logic [3:0] y_index_in,
  output logic exec_en_out,
  output logic pc_inc_out,
  output logic skip_pending_out,
  output logic vd_pd_enable_out
);

  // ==========================================================
  // State
  cst_state_t state_q, state_d;
  logic skip_q, skip_d;
  logic vdpd_q, vdpd_d;
  logic live;
  logic ptest2_hit;
  cst_op_t cur_op;
  cst_eval_if ev ();

  cst_skip_eval u_eval (
    .bus(ev.eval)
  );

  // ==========================================================
  // Decode
  // A word is live only when fetched and not being skipped
  assign live = instr_valid_in & ~skip_q;
  assign ptest2_hit = (state_q == CST_ST_PTEST2) && (instr_in == CST_OPC_PTEST_W2);

  always_comb begin
    cur_op = CST_OP_NONE;
    if (live) begin
      if (ptest2_hit) begin
        cur_op = CST_OP_PIN;
      end else if (instr_in[9:2] == CST_OPC_MBIT_HI) begin
        cur_op = CST_OP_MEM;
      end else if (instr_in == CST_OPC_CTEST) begin
        cur_op = CST_OP_CARRY;
      end
    end
  end

  // Operand hookup; carry is only read here, never written back
  assign ev.op = cur_op;
  assign ev.bit_sel = instr_in[CST_MBIT_SEL_LSB +: 2];
  assign ev.mem_nibble = mem_nibble_in;
  assign ev.carry_flag = carry_flag_in;
  assign ev.port_pins = port_pins_in;
  assign ev.y_index = y_index_in;

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    skip_d = skip_q;
    vdpd_d = vdpd_q;
    if (instr_valid_in) begin
      state_d = CST_ST_RUN;
      skip_d = 1'b0;
      if (live) begin
        if (cur_op != CST_OP_NONE) begin
          skip_d = ev.skip_true;
        end else if (instr_in == CST_OPC_PTEST_W1) begin
          state_d = CST_ST_PTEST2;
        end else if (instr_in == CST_OPC_VDPD) begin
          vdpd_d = 1'b1;
        end
      end
    end
  end

  // Only registers; reset clears the powerdown keep-alive too
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= CST_ST_RUN;
      skip_q <= CST_SKIP_RST;
      vdpd_q <= CST_VDPD_RST;
    end else begin
      state_q <= state_d;
      skip_q <= skip_d;
      vdpd_q <= vdpd_d;
    end
  end

  // ==========================================================
  // Outputs
  // Suppressed word still consumes its fetch slot
  assign exec_en_out = live;
  assign pc_inc_out = instr_valid_in;
  assign skip_pending_out = skip_q;
  assign vd_pd_enable_out = vdpd_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  // First word of the port test, decoded live from the run state
  sequence s_ptest_first;
    live && (instr_in == CST_OPC_PTEST_W1) && (state_q == CST_ST_RUN);
  endsequence

  // Second word with the selected pin low; Y past the last pin never matches
  sequence s_ptest_second_zero;
    instr_valid_in && (instr_in == CST_OPC_PTEST_W2) && (y_index_in <= CST_Y_MAX)
      && !port_pins_in[y_index_in[2:0]];
  endsequence

  // Second word with the selected pin high
  sequence s_ptest_second_one;
    instr_valid_in && (instr_in == CST_OPC_PTEST_W2) && (y_index_in <= CST_Y_MAX)
      && port_pins_in[y_index_in[2:0]];
  endsequence

  // Live detector word raises the keep-alive one edge later
  property p_vdpd_set;
    live && (instr_in == CST_OPC_VDPD) |=> vd_pd_enable_out;
  endproperty
  a_vdpd_set: assert property (p_vdpd_set) else $error("detector enable not set");

  // Keep-alive is sticky; only reset, which disables this, may drop it
  property p_vdpd_hold;
    vd_pd_enable_out |=> vd_pd_enable_out [*3];
  endproperty
  a_vdpd_hold: assert property (p_vdpd_hold) else $error("detector enable dropped");

  // Memory bit low: next word is suppressed
  property p_mem_zero;
    live && (state_q == CST_ST_RUN) && (instr_in[9:2] == CST_OPC_MBIT_HI)
      && !mem_nibble_in[instr_in[1:0]] |=> skip_pending_out ##0 !exec_en_out [*1];
  endproperty
  a_mem_zero: assert property (p_mem_zero) else $error("mem bit zero no skip");

  // Memory bit high: next word runs
  property p_mem_one;
    live && (state_q == CST_ST_RUN) && (instr_in[9:2] == CST_OPC_MBIT_HI)
      && mem_nibble_in[instr_in[1:0]] |=> !skip_pending_out;
  endproperty
  a_mem_one: assert property (p_mem_one) else $error("mem bit one skipped");

  // Carry low: next word is suppressed
  property p_carry_zero;
    live && (state_q == CST_ST_RUN) && (instr_in == CST_OPC_CTEST) && !carry_flag_in
      |=> skip_pending_out;
  endproperty
  a_carry_zero: assert property (p_carry_zero) else $error("carry zero no skip");

  // Carry high: next word runs
  property p_carry_one;
    live && (state_q == CST_ST_RUN) && (instr_in == CST_OPC_CTEST) && carry_flag_in
      |=> !skip_pending_out;
  endproperty
  a_carry_one: assert property (p_carry_one) else $error("carry one skipped");

  // Back to back port test with the pin low sets the skip
  property p_ptest_skip;
    s_ptest_first ##1 s_ptest_second_zero |=> skip_pending_out;
  endproperty
  a_ptest_skip: assert property (p_ptest_skip) else $error("pin zero no skip");

  // Back to back port test with the pin high lets the next word run
  property p_ptest_pin_one;
    s_ptest_first ##1 s_ptest_second_one |=> !skip_pending_out;
  endproperty
  a_ptest_pin_one: assert property (p_ptest_pin_one) else $error("pin one skipped");

  // The first word alone must never decide the skip
  property p_ptest_one_word_no_skip;
    s_ptest_first |=> !skip_pending_out;
  endproperty
  a_ptest_one_word: assert property (p_ptest_one_word_no_skip) else $error("early pin skip");

  // A suppressed word still advances the counter and clears the skip
  property p_suppress;
    skip_pending_out && instr_valid_in |-> !exec_en_out && pc_inc_out ##1 !skip_pending_out;
  endproperty
  a_suppress: assert property (p_suppress) else $error("skipped word not suppressed");

  // Detector word under a skip is dropped, so the keep-alive stays low
  property p_vdpd_refused;
    skip_pending_out && instr_valid_in && (instr_in == CST_OPC_VDPD) && !vd_pd_enable_out
      |=> !vd_pd_enable_out;
  endproperty
  a_vdpd_refused: assert property (p_vdpd_refused) else $error("skipped detector word taken");

  // Idle fetch slots neither consume nor create a skip
  property p_idle_hold;
    !instr_valid_in |=> $stable(skip_pending_out);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("skip changed while idle");

  // With no skip pending a fetched word always executes
  property p_exec_live;
    instr_valid_in && !skip_pending_out |-> exec_en_out;
  endproperty
  a_exec_live: assert property (p_exec_live) else $error("live word not executed");

endmodule
`default_nettype wire

/* File: rtl/cst_pkg.sv */
/*
  Constants and types for the skip-test decode slice of the 4-bit core.
  Assumes a 10-bit instruction word and one instruction cycle per clock.
*/
package cst_pkg;

  // ==========================================================
  // Instruction encodings
  localparam logic [9:0] CST_OPC_VDPD = 10'h293;
  localparam logic [7:0] CST_OPC_MBIT_HI = 8'h08;
  localparam logic [9:0] CST_OPC_CTEST = 10'h3F0;
  localparam logic [9:0] CST_OPC_PTEST_W1 = 10'h024;
  localparam logic [9:0] CST_OPC_PTEST_W2 = 10'h02B;

  // ==========================================================
  // Field positions and limits
  localparam int CST_MBIT_SEL_LSB = 0;
  localparam logic [3:0] CST_Y_MAX = 4'h5;
  localparam int CST_PORT_W = 6;

  // ==========================================================
  // Reset values
  localparam logic CST_VDPD_RST = 1'b0;
  localparam logic CST_SKIP_RST = 1'b0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CST_ST_RUN = 2'b01,
    CST_ST_PTEST2 = 2'b10
  } cst_state_t;

  typedef enum logic [2:0] {
    CST_OP_NONE = 3'h0,
    CST_OP_MEM = 3'h1,
    CST_OP_CARRY = 3'h2,
    CST_OP_PIN = 3'h3
  } cst_op_t;

endpackage

/* File: rtl/cst_eval_if.sv */
/*
  Carrier between the skip sequencer and the condition evaluator.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface cst_eval_if;
  import cst_pkg::*;
  cst_op_t op;
  logic [1:0] bit_sel;
  logic [3:0] mem_nibble;
  logic carry_flag;
  logic [CST_PORT_W-1:0] port_pins;
  logic [3:0] y_index;
  logic skip_true;

  modport seq (output op, bit_sel, mem_nibble, carry_flag, port_pins, y_index,
    input skip_true);
  modport eval (input op, bit_sel, mem_nibble, carry_flag, port_pins, y_index,
    output skip_true);
endinterface
`default_nettype wire

/* File: rtl/cst_skip_eval.sv */
/*
  Combinational skip condition evaluator.
  Assumes the sequencer presents operands in the cycle the test executes.
*/
`timescale 1ns/1ps
`default_nettype none
module cst_skip_eval
  import cst_pkg::*;
(
  cst_eval_if.eval bus
);

  // ==========================================================
  // Condition select
  // Pins beyond the last valid Y give no skip rather than an X pick
  always_comb begin
    bus.skip_true = 1'b0;
    case (bus.op)
      CST_OP_MEM: begin
        bus.skip_true = ~bus.mem_nibble[bus.bit_sel];
      end
      CST_OP_CARRY: begin
        bus.skip_true = ~bus.carry_flag;
      end
      CST_OP_PIN: begin
        if (bus.y_index <= CST_Y_MAX) begin
          bus.skip_true = ~bus.port_pins[bus.y_index[2:0]];
        end
      end
      default: begin
        bus.skip_true = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: tb/test_cst_skip_core.sv */
/*
  Self-checking bench for the skip-test decode slice of the 4-bit core.
  Assumes one clock, no software-visible registers, operands current with the word.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module test_cst_skip_core;
  import cst_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic v = 1'b0;
  logic [9:0] w = 10'h000;
  logic [3:0] nib = 4'h0;
  logic cy = 1'b0;
  logic [CST_PORT_W-1:0] pins = '0;
  logic [3:0] y = 4'h0;
  logic [3:0] n_n = 4'h0;
  logic c_n = 1'b0;
  logic [CST_PORT_W-1:0] p_n = '0;
  logic [3:0] y_n = 4'h0;
  logic exec_en, pc_inc, skip_p, vd;
  logic skip_e, vd_e, ptest_e;
  int fail_count = 0;
  int tests_run = 0;
  int i;

  cst_skip_core dut (.mclk_in(mclk_in), .srst_in(srst_in), .instr_valid_in(v),
    .instr_in(w), .mem_nibble_in(nib), .carry_flag_in(cy), .port_pins_in(pins),
    .y_index_in(y), .exec_en_out(exec_en), .pc_inc_out(pc_inc),
    .skip_pending_out(skip_p), .vd_pd_enable_out(vd));

  // ==========================================================
  // Clock and watchdog, the latter far beyond the ~500 cycles used
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    #20000;
    fail_count++;
    close_out();
  end

  // ==========================================================
  // Reference: does this live word set up a skip
  function automatic logic want_skip(logic [9:0] wd, logic pend);
    if (wd[9:2] == CST_OPC_MBIT_HI) return ~n_n[wd[1:0]];
    if (wd == CST_OPC_CTEST) return ~c_n;
    if (pend && wd == CST_OPC_PTEST_W2) return (y_n <= CST_Y_MAX) && !p_n[y_n];
    return 1'b0;
  endfunction

  // Random word, biased toward the opcodes of interest
  function automatic logic [9:0] pick();
    case ($urandom % 6)
      0: return CST_OPC_CTEST;
      1: return {CST_OPC_MBIT_HI, 2'($urandom)};
      2: return CST_OPC_PTEST_W1;
      3: return CST_OPC_PTEST_W2;
      4: return CST_OPC_VDPD;
      default: return 10'($urandom);
    endcase
  endfunction

  task automatic rops();
    n_n = 4'($urandom);
    c_n = 1'($urandom);
    p_n = CST_PORT_W'($urandom);
    y_n = 4'($urandom);
  endtask

  // One cycle: drive, check what the previous edge left, advance the model
  task automatic cyc(input logic vv, input logic [9:0] ww);
    @(posedge mclk_in);
    v <= vv;
    w <= ww;
    nib <= n_n;
    cy <= c_n;
    pins <= p_n;
    y <= y_n;
    #1;
    `CHK("skip_pending", skip_e, skip_p)
    `CHK("vd_pd_enable", vd_e, vd)
    `CHK("exec_en", vv & ~skip_e, exec_en)
    `CHK("pc_inc", vv, pc_inc)
    if (vv && skip_e) begin
      skip_e = 1'b0;
      ptest_e = 1'b0;
    end else if (vv) begin
      vd_e = vd_e | (ww == CST_OPC_VDPD);
      skip_e = want_skip(ww, ptest_e);
      ptest_e = (ww == CST_OPC_PTEST_W1);
    end
  endtask

  task automatic do_reset();
    @(posedge mclk_in);
    srst_in <= 1'b1;
    v <= 1'b0;
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    skip_e = 1'b0;
    vd_e = 1'b0;
    ptest_e = 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Directed corners first, then random traffic
  initial begin
    void'($urandom(32'h20E5));
    do_reset();
    // Every bit select, bit zero and bit one
    for (i = 0; i < 8; i++) begin
      rops();
      n_n = i[2] ? 4'hF : ~(4'h1 << i[1:0]);
      cyc(1'b1, {CST_OPC_MBIT_HI, i[1:0]});
      rops();
      cyc(1'b1, pick());
    end
    $display("test bit select done");
    // Back to back carry tests: with carry low the second is suppressed, never decoded; with carry high both run
    c_n = 1'b0;
    cyc(1'b1, CST_OPC_CTEST);
    cyc(1'b1, CST_OPC_CTEST);
    c_n = 1'b1;
    cyc(1'b1, CST_OPC_CTEST);
    cyc(1'b1, CST_OPC_CTEST);
    $display("test carry done");
    // Port test for Y 0..7, pin zero and one, with an idle gap
    for (i = 0; i < 16; i++) begin
      rops();
      y_n = 4'(i[2:0]);
      p_n = i[3] ? '1 : ~(CST_PORT_W'(1) << i[2:0]);
      cyc(1'b1, CST_OPC_PTEST_W1);
      cyc(1'b0, 10'h000);
      cyc(1'b1, CST_OPC_PTEST_W2);
      cyc(1'b1, pick());
    end
    $display("test port pin done");
    // Detector word refused under a skip, then taken, then cleared by reset
    c_n = 1'b0;
    cyc(1'b1, CST_OPC_CTEST);
    cyc(1'b1, CST_OPC_VDPD);
    cyc(1'b1, CST_OPC_VDPD);
    cyc(1'b0, 10'h000);
    do_reset();
    cyc(1'b0, 10'h000);
    $display("test detector done");
    for (i = 0; i < 400; i++) begin
      rops();
      cyc(1'($urandom % 4 != 0), pick());
    end
    $display("test random done");
    close_out();
  end
endmodule
`default_nettype wire
